//--- pkg/idp_pkg.sv
`default_nettype none
package idp_pkg;
  // --------------------------------------------------------------
  // Port geometry and timing
  // --------------------------------------------------------------
  localparam int NPIN = 7;
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_MIN_NS = 30_000;
  // Least time, so the count rounds up.
  localparam int PULSE_CYC = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CNT_W = 12;
  localparam int PWM_W = 24;
  localparam int NIRQ = 6;
  // Pin indices by default role.
  localparam int PIN_CLR = 0;
  localparam int PIN_PROT = 1;
  localparam int PIN_OFF = 2;
  localparam int PIN_TRIG = 3;
  localparam int PIN_INH = 4;
  localparam int PIN_SON = 5;
  localparam int PIN_SOFF = 6;
  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_INV = 8'h04;
  localparam logic [7:0] OFF_OUTV = 8'h08;
  localparam logic [7:0] OFF_PER = 8'h0C;
  localparam logic [7:0] OFF_DUTY = 8'h10;
  localparam logic [7:0] OFF_PINST = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;
  localparam logic [7:0] OFF_IST = 8'h1C;
  localparam logic [7:0] OFF_ICLR = 8'h20;
  localparam logic [7:0] OFF_IEN = 8'h24;
  localparam logic [7:0] OFF_CTRL = 8'h28;
  localparam logic [13:0] MODE_RST = 14'h0000;
  localparam logic [6:0] INV_RST = 7'h00;
  localparam logic [6:0] OUTV_RST = 7'h00;
  localparam logic [23:0] PER_RST = 24'h0F_4240;
  localparam logic [23:0] DUTY_RST = 24'h01_86A0;
  // Interrupt status bit positions.
  localparam int IRQ_CLR_RX = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_SON = 2;
  localparam int IRQ_SOFF = 3;
  localparam int IRQ_INH = 4;
  localparam int IRQ_CLR_TX = 5;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DFLT = 2'h0,
    MODE_IN = 2'h1,
    MODE_OUT = 2'h2,
    MODE_PWM = 2'h3
  } idp_mode_t;
  typedef enum logic [1:0] {
    EM_IDLE = 2'b01,
    EM_LOW = 2'b10
  } idp_em_t;
endpackage
`default_nettype wire

//--- pkg/idp_sig_if.sv
`default_nettype none
interface idp_sig_if #(parameter int N = 7, parameter int PW = 24);
  logic [N-1:0] pin_raw;
  logic [N-1:0] inv;
  logic [N-1:0] mask;
  logic [N-1:0] lvl;
  logic [N-1:0] pulse;
  logic [PW-1:0] period;
  logic [PW-1:0] duty;
  logic pwm_low;
  modport qual (input pin_raw, inv, mask, output lvl, pulse);
  modport pwm (input period, duty, output pwm_low);
  modport core (output pin_raw, inv, mask, period, duty, input lvl, pulse, pwm_low);
endinterface
`default_nettype wire

//--- core/idp_in_qual.sv
`default_nettype none
module idp_in_qual #(parameter int N = 7, parameter int CW = 12) (
  input wire logic clk,
  input wire logic rst_n,
  idp_sig_if.qual sig
);
  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] prev_q;
  logic [N-1:0] armed_q;
  logic [N-1:0] pulse_q;
  logic [CW-1:0] cnt_q [N];
  wire [N-1:0] norm = s2_q ^ sig.inv;
  assign sig.lvl = s2_q;
  assign sig.pulse = pulse_q;

  // --------------------------------------------------------------
  // Synchroniser, falling edge and low-width qualification
  // --------------------------------------------------------------
  // A glitch shorter than the least width never raises a pulse; the synchronised level output lvl still passes it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      prev_q <= '1;
      armed_q <= '0;
      pulse_q <= '0;
      for (int i = 0; i < N; i++) cnt_q[i] <= '0;
    end else begin
      s1_q <= sig.pin_raw;
      s2_q <= s1_q;
      prev_q <= norm;
      for (int i = 0; i < N; i++) begin
        pulse_q[i] <= 1'b0;
        if (prev_q[i] && !norm[i] && !sig.mask[i]) begin
          armed_q[i] <= 1'b1;
          cnt_q[i] <= CW'(1);
        end else if (armed_q[i] && !norm[i] && !sig.mask[i]) begin
          if (cnt_q[i] == CW'(idp_pkg::PULSE_CYC - 1)) begin
            pulse_q[i] <= 1'b1;
            armed_q[i] <= 1'b0;
          end else begin
            cnt_q[i] <= cnt_q[i] + CW'(1);
          end
        end else begin
          armed_q[i] <= 1'b0;
        end
      end
    end
  end

  logic [CW-1:0] run_q;
  always_ff @(posedge clk) begin
    if (!rst_n) run_q <= '0;
    else run_q <= norm[0] ? '0 : run_q + CW'(1);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  qual_width_a: assert property (
    pulse_q[0] |-> $past(run_q) >= CW'(idp_pkg::PULSE_CYC - 1))
    else $error("pulse accepted before the least low width");
endmodule
`default_nettype wire

//--- core/idp_pwm.sv
`default_nettype none
module idp_pwm #(parameter int PW = 24) (
  input wire logic clk,
  input wire logic rst_n,
  idp_sig_if.pwm sig
);
  logic [PW-1:0] cnt_q;
  logic low_q;
  wire wrap = (cnt_q >= sig.period - PW'(1)) || (sig.period == '0);
  assign sig.pwm_low = low_q;

  // Duty is counted in clock cycles of low level within each period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      low_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + PW'(1);
      low_q <= (sig.period != '0) && (cnt_q < sig.duty);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  pwm_period_a: assert property (
    (sig.period > PW'(1)) && (cnt_q == sig.period - PW'(1)) |=> cnt_q == '0)
    else $error("pwm period did not wrap");
endmodule
`default_nettype wire

//--- core/idp_port.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none
// What this block does
// - Seven pins, each default function, general input or general output.
// - Defaults: clear, protection level, off level, trigger, inhibit, sync on, sync off.
// - Every pulse, in or out, is a high-to-low transition.
// - A valid pulse stays low at least 30 us, both directions.
// - General output, normal polarity: True drives low, False drives high.
// - General input samples the pin level and makes it readable.
// - PWM output has programmable period and duty.
// - Normal polarity: duty is the low fraction of each period.
// - Inversion reverses the valid level of pulses and levels per pin; the general-input level read from PINST is the raw pin level.
// - Inhibit pin: high disables output by default, low when inverted.
// - Protection-clear pin is bidirectional: accepts and emits pulses.
// - Valid clear pulse during protection clears the protection state.
// - Output off-to-on without protection emits one clear-pin pulse.
// - Protection indicator: high when unprotected, low under protection.
// - Output-off indicator: high while output off, low while on.
// - Trigger-in pulse drives the external trigger when selected.
module idp_port #(
  parameter int NP = idp_pkg::NPIN,
  parameter int PW = idp_pkg::PWM_W
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Instrument side
  input wire logic PROT_ACTIVE_IN,
  input wire logic OUTPUT_ON_IN,
  output logic PROT_CLEAR_OUT,
  output logic TRIG_OUT,
  output logic INHIBIT_OUT,
  output logic SYNC_ON_OUT,
  output logic SYNC_OFF_OUT,
  output logic IRQ_OUT,
  // Port pins
  input wire logic [NP-1:0] PIN_IN,
  output logic [NP-1:0] PIN_OUT,
  output logic [NP-1:0] PIN_OE_N_OUT
);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic is_mode(input logic [13:0] m, input int i,
                                   input idp_pkg::idp_mode_t k);
    return m[2*i +: 2] == k;
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic [13:0] mode_q;
  logic [NP-1:0] inv_q;
  logic [NP-1:0] outv_q;
  logic [PW-1:0] per_q;
  logic [PW-1:0] duty_q;
  logic [idp_pkg::NIRQ-1:0] ist_q;
  logic [idp_pkg::NIRQ-1:0] ist_d;
  logic [idp_pkg::NIRQ-1:0] ien_q;
  logic ctrl_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic on_prev_q;
  logic inh_q;
  logic clr_q;
  logic trig_q;
  logic son_q;
  logic soff_q;
  logic irq_q;
  logic [NP-1:0] pin_o_q;
  logic [NP-1:0] pin_oe_n_q;
  idp_pkg::idp_em_t em_q;
  idp_pkg::idp_em_t em_d;
  logic [idp_pkg::CNT_W-1:0] em_cnt_q;

  idp_sig_if #(.N(NP), .PW(PW)) sig ();

  // --------------------------------------------------------------
  // Input qualification and PWM source
  // --------------------------------------------------------------
  idp_in_qual #(.N(NP), .CW(idp_pkg::CNT_W)) u_qual (
    .clk(SYS_CLK_IN),
    .rst_n(RESETN_IN),
    .sig(sig.qual)
  );
  // One PWM source is shared; every pin in PWM mode shows the same wave, or its complement where its inversion bit is set.
  idp_pwm #(.PW(PW)) u_pwm (
    .clk(SYS_CLK_IN),
    .rst_n(RESETN_IN),
    .sig(sig.pwm)
  );
  wire emitting = (em_q == idp_pkg::EM_LOW);
  assign sig.pin_raw = PIN_IN;
  assign sig.inv = inv_q;
  // The clear pin ignores its own outgoing pulse.
  assign sig.mask = {{(NP-1){1'b0}}, emitting};
  assign sig.period = per_q;
  assign sig.duty = duty_q;

  // --------------------------------------------------------------
  // Default functions
  // --------------------------------------------------------------
  wire dflt_clr = is_mode(mode_q, idp_pkg::PIN_CLR, idp_pkg::MODE_DFLT);
  wire dflt_prot = is_mode(mode_q, idp_pkg::PIN_PROT, idp_pkg::MODE_DFLT);
  wire dflt_off = is_mode(mode_q, idp_pkg::PIN_OFF, idp_pkg::MODE_DFLT);
  wire dflt_trig = is_mode(mode_q, idp_pkg::PIN_TRIG, idp_pkg::MODE_DFLT);
  wire dflt_inh = is_mode(mode_q, idp_pkg::PIN_INH, idp_pkg::MODE_DFLT);
  wire dflt_son = is_mode(mode_q, idp_pkg::PIN_SON, idp_pkg::MODE_DFLT);
  wire dflt_soff = is_mode(mode_q, idp_pkg::PIN_SOFF, idp_pkg::MODE_DFLT);
  wire clr_rx = dflt_clr && sig.pulse[idp_pkg::PIN_CLR];
  wire clr_go = clr_rx && PROT_ACTIVE_IN;
  wire trig_go = dflt_trig && ctrl_q && sig.pulse[idp_pkg::PIN_TRIG];
  wire son_go = dflt_son && sig.pulse[idp_pkg::PIN_SON];
  wire soff_go = dflt_soff && sig.pulse[idp_pkg::PIN_SOFF];
  // Inhibit is a level: pin level XOR inversion, valid high by default.
  wire inh_lvl = dflt_inh && (sig.lvl[idp_pkg::PIN_INH] ^ inv_q[idp_pkg::PIN_INH]);
  wire em_start = dflt_clr && OUTPUT_ON_IN && !on_prev_q && !PROT_ACTIVE_IN;

  // Pins that actively drive in their default role, and their normal level.
  wire [NP-1:0] dflt_drv = {4'h0, 1'b1, 1'b1, emitting};
  wire [NP-1:0] dflt_lvl = {4'hF, !OUTPUT_ON_IN, !PROT_ACTIVE_IN, 1'b0};

  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  logic [NP-1:0] drv;
  logic [NP-1:0] nxt_o;
  for (genvar g = 0; g < NP; g++) begin : g_pin
    wire m_out = is_mode(mode_q, g, idp_pkg::MODE_OUT);
    wire m_pwm = is_mode(mode_q, g, idp_pkg::MODE_PWM);
    wire m_dflt = is_mode(mode_q, g, idp_pkg::MODE_DFLT);
    assign drv[g] = m_out || m_pwm || (m_dflt && dflt_drv[g]);
    assign nxt_o[g] = inv_q[g] ^ (m_pwm ? !sig.pwm_low :
                                  m_out ? !outv_q[g] : dflt_lvl[g]);
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      pin_o_q <= '1;
      pin_oe_n_q <= '1;
    end else begin
      pin_o_q <= nxt_o;
      pin_oe_n_q <= ~drv;
    end
  end

  // --------------------------------------------------------------
  // Clear-pin pulse emitter
  // --------------------------------------------------------------
  always_comb begin
    em_d = em_q;
    case (em_q)
      idp_pkg::EM_IDLE: if (em_start) em_d = idp_pkg::EM_LOW;
      idp_pkg::EM_LOW: begin
        if (em_cnt_q == idp_pkg::CNT_W'(idp_pkg::PULSE_CYC - 1)) em_d = idp_pkg::EM_IDLE;
      end
      default: em_d = idp_pkg::EM_IDLE;
    endcase
  end

  // The emitter always runs its full width, even if the mode changes midway; the clear pin drives it only while in default mode.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      em_q <= idp_pkg::EM_IDLE;
      em_cnt_q <= '0;
      on_prev_q <= 1'b0;
    end else begin
      em_q <= em_d;
      em_cnt_q <= emitting ? em_cnt_q + idp_pkg::CNT_W'(1) : '0;
      on_prev_q <= OUTPUT_ON_IN;
    end
  end

  // --------------------------------------------------------------
  // Instrument strobes and interrupts
  // --------------------------------------------------------------
  wire [idp_pkg::NIRQ-1:0] ev = {em_start, inh_lvl && !inh_q, soff_go, son_go, trig_go, clr_rx};
  wire apb_acc = PSEL_IN && PENABLE_IN && pready_q;
  wire apb_wr = apb_acc && PWRITE_IN;
  wire [idp_pkg::NIRQ-1:0] iclr = (apb_wr && PADDR_IN == idp_pkg::OFF_ICLR) ?
                                  PWDATA_IN[idp_pkg::NIRQ-1:0] : '0;
  // A new event in the clearing cycle stays set.
  assign ist_d = (ist_q & ~iclr) | ev;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      clr_q <= 1'b0;
      trig_q <= 1'b0;
      son_q <= 1'b0;
      soff_q <= 1'b0;
      inh_q <= 1'b0;
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      clr_q <= clr_go;
      trig_q <= trig_go;
      son_q <= son_go;
      soff_q <= soff_go;
      inh_q <= inh_lvl;
      ist_q <= ist_d;
      irq_q <= |(ist_q & ien_q);
    end
  end

  // --------------------------------------------------------------
  // APB register file
  // --------------------------------------------------------------
  // Every access takes one wait state, which keeps the read mux registered.
  wire hit = (PADDR_IN[1:0] == 2'b00) && (PADDR_IN <= idp_pkg::OFF_CTRL);
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (PADDR_IN)
      idp_pkg::OFF_MODE: rd_val = 32'(mode_q);
      idp_pkg::OFF_INV: rd_val = 32'(inv_q);
      idp_pkg::OFF_OUTV: rd_val = 32'(outv_q);
      idp_pkg::OFF_PER: rd_val = 32'(per_q);
      idp_pkg::OFF_DUTY: rd_val = 32'(duty_q);
      idp_pkg::OFF_PINST: rd_val = 32'(sig.lvl);
      idp_pkg::OFF_STATE: rd_val = 32'({emitting, inh_q, OUTPUT_ON_IN, PROT_ACTIVE_IN});
      idp_pkg::OFF_IST: rd_val = 32'(ist_q);
      idp_pkg::OFF_IEN: rd_val = 32'(ien_q);
      idp_pkg::OFF_CTRL: rd_val = 32'(ctrl_q);
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= PSEL_IN && PENABLE_IN && !pready_q;
      pslverr_q <= PSEL_IN && PENABLE_IN && !pready_q && !hit;
      prdata_q <= (PSEL_IN && !PWRITE_IN && hit) ? rd_val : '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      mode_q <= idp_pkg::MODE_RST;
      inv_q <= idp_pkg::INV_RST;
      outv_q <= idp_pkg::OUTV_RST;
      per_q <= idp_pkg::PER_RST;
      duty_q <= idp_pkg::DUTY_RST;
      ien_q <= '0;
      ctrl_q <= 1'b0;
    end else if (apb_wr) begin
      case (PADDR_IN)
        idp_pkg::OFF_MODE: mode_q <= PWDATA_IN[13:0];
        idp_pkg::OFF_INV: inv_q <= PWDATA_IN[NP-1:0];
        idp_pkg::OFF_OUTV: outv_q <= PWDATA_IN[NP-1:0];
        idp_pkg::OFF_PER: per_q <= PWDATA_IN[PW-1:0];
        idp_pkg::OFF_DUTY: duty_q <= PWDATA_IN[PW-1:0];
        idp_pkg::OFF_IEN: ien_q <= PWDATA_IN[idp_pkg::NIRQ-1:0];
        idp_pkg::OFF_CTRL: ctrl_q <= PWDATA_IN[0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign PROT_CLEAR_OUT = clr_q;
  assign TRIG_OUT = trig_q;
  assign INHIBIT_OUT = inh_q;
  assign SYNC_ON_OUT = son_q;
  assign SYNC_OFF_OUT = soff_q;
  assign IRQ_OUT = irq_q;
  assign PIN_OUT = pin_o_q;
  assign PIN_OE_N_OUT = pin_oe_n_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  logic [idp_pkg::CNT_W-1:0] em_run_q;
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) em_run_q <= '0;
    else em_run_q <= emitting ? em_run_q + idp_pkg::CNT_W'(1) : '0;
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_emit_begin;
    em_start && em_q == idp_pkg::EM_IDLE;
  endsequence
  sequence s_pin_low;
    !pin_oe_n_q[idp_pkg::PIN_CLR] && pin_o_q[idp_pkg::PIN_CLR] == $past(inv_q[idp_pkg::PIN_CLR]);
  endsequence
  emit_start_a: assert property (
    s_emit_begin |=> emitting ##1 s_pin_low)
    else $error("clear pin pulse not emitted on turn-on");
  emit_width_a: assert property (
    $fell(emitting) |-> em_run_q == idp_pkg::CNT_W'(idp_pkg::PULSE_CYC))
    else $error("emitted pulse width wrong");
  prot_clear_a: assert property (
    PROT_CLEAR_OUT |-> $past(PROT_ACTIVE_IN) && $past(sig.pulse[idp_pkg::PIN_CLR]))
    else $error("protection clear without qualified pulse");
  prot_ind_a: assert property (
    dflt_prot && !inv_q[idp_pkg::PIN_PROT] && PROT_ACTIVE_IN
    |=> !PIN_OUT[idp_pkg::PIN_PROT] && !PIN_OE_N_OUT[idp_pkg::PIN_PROT])
    else $error("protection indicator not low");
  off_ind_a: assert property (
    dflt_off && !inv_q[idp_pkg::PIN_OFF] && !OUTPUT_ON_IN |=> PIN_OUT[idp_pkg::PIN_OFF])
    else $error("output-off indicator not high");
  gpo_true_a: assert property (
    is_mode(mode_q, 6, idp_pkg::MODE_OUT) && !inv_q[6] && outv_q[6]
    |=> !PIN_OUT[6] && !PIN_OE_N_OUT[6])
    else $error("general output true not low");
  gpo_inv_a: assert property (
    is_mode(mode_q, 6, idp_pkg::MODE_OUT) && inv_q[6] && outv_q[6] |=> PIN_OUT[6])
    else $error("inverted output not high");
  gpi_release_a: assert property (
    is_mode(mode_q, 6, idp_pkg::MODE_IN) |=> PIN_OE_N_OUT[6])
    else $error("input pin is driven");
  inhibit_lvl_a: assert property (
    dflt_inh && (sig.lvl[idp_pkg::PIN_INH] != inv_q[idp_pkg::PIN_INH]) |=> INHIBIT_OUT)
    else $error("inhibit level not passed");
  trig_sel_a: assert property (
    TRIG_OUT |-> $past(ctrl_q) && $past(sig.pulse[idp_pkg::PIN_TRIG]))
    else $error("trigger without selection");
  pwm_low_a: assert property (
    is_mode(mode_q, 6, idp_pkg::MODE_PWM) && !inv_q[6] && sig.pwm_low |=> !PIN_OUT[6])
    else $error("pwm low phase not low");
endmodule
`default_nettype wire

//--- bench/idp_ext_model.sv
`default_nettype none
module idp_ext_model (
  // Clock
  input wire logic clk_in,
  // Device side of the pins
  input wire logic [6:0] dev_out_in,
  input wire logic [6:0] dev_oe_n_in,
  // Resolved pin levels
  output logic [6:0] pin_lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] ext_en_q = 7'h00;
  logic [6:0] ext_lvl_q = 7'h7F;
  // A pin that nobody drives floats up to its pull-up level.
  assign pin_lvl_out = (~dev_oe_n_in & dev_out_in) | (dev_oe_n_in & (~ext_en_q | ext_lvl_q));
  task automatic hold(input int i, input logic v);
    @(posedge clk_in);
    ext_en_q[i] <= 1'b1;
    ext_lvl_q[i] <= v;
  endtask
  task automatic release_pin(input int i);
    @(posedge clk_in);
    ext_en_q[i] <= 1'b0;
  endtask
  // The low phase lasts exactly low_cyc clock edges.
  task automatic pulse(input int i, input int low_cyc);
    hold(i, 1'b0);
    repeat (low_cyc - 1) @(posedge clk_in);
    hold(i, 1'b1);
    release_pin(i);
  endtask
endmodule
`default_nettype wire

//--- bench/idp_port_tb_top.sv
`default_nettype none
module idp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clk, rst_n, psel, pen, pwr, prot, on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, rerr, clr_o, trig_o, inh_o, son_o, soff_o, irq_o;
  logic [6:0] pin_lvl, pin_out, pin_oe_n;
  int n_mismatch = 0;
  int compares = 0;
  int cnt [7] = '{default: 0};
  int n;
  int pins [4] = '{0, 3, 5, 6};
  int duties [2] = '{3, 7};
  idp_port dut (
    .SYS_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PROT_ACTIVE_IN(prot),
    .OUTPUT_ON_IN(on), .PROT_CLEAR_OUT(clr_o), .TRIG_OUT(trig_o), .INHIBIT_OUT(inh_o),
    .SYNC_ON_OUT(son_o), .SYNC_OFF_OUT(soff_o), .IRQ_OUT(irq_o), .PIN_IN(pin_lvl),
    .PIN_OUT(pin_out), .PIN_OE_N_OUT(pin_oe_n)
  );
  idp_ext_model ext (
    .clk_in(clk), .dev_out_in(pin_out), .dev_oe_n_in(pin_oe_n), .pin_lvl_out(pin_lvl)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (clr_o === 1'b1) cnt[0]++;
    if (trig_o === 1'b1) cnt[3]++;
    if (son_o === 1'b1) cnt[5]++;
    if (soff_o === 1'b1) cnt[6]++;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The wait for the answer is open ended; only the watchdog cuts it short.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, prot, on} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pin_oe_n, 7'h79);
    chk(pin_out[2:1], 2'h3);
    apb(1'b0, idp_pkg::OFF_PER, 32'h0000_0000);
    chk(rdata, 32'h000F_4240);
    prot <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pin_out[1], 1'b0);
    ext.pulse(0, 2999);
    repeat (20) @(posedge clk);
    chk(cnt[0], 0);
    ext.pulse(3, 3000);
    repeat (20) @(posedge clk);
    chk(cnt[3], 0);
    apb(1'b1, idp_pkg::OFF_CTRL, 32'h0000_0001);
    foreach (pins[i]) begin
      ext.pulse(pins[i], 3000);
      repeat (20) @(posedge clk);
      chk(cnt[pins[i]], 1);
    end
    chk(irq_o, 1'b0);
    ext.hold(4, 1'b1);
    repeat (10) @(posedge clk);
    chk(inh_o, 1'b1);
    ext.hold(4, 1'b0);
    repeat (10) @(posedge clk);
    chk(inh_o, 1'b0);
    apb(1'b1, idp_pkg::OFF_INV, 32'h0000_0010);
    repeat (10) @(posedge clk);
    chk(inh_o, 1'b1);
    apb(1'b1, idp_pkg::OFF_INV, 32'h0000_0000);
    ext.release_pin(4);
    prot <= 1'b0;
    apb(1'b1, idp_pkg::OFF_IEN, 32'h0000_0020);
    ext.pulse(0, 3000);
    repeat (20) @(posedge clk);
    chk(cnt[0], 1);
    @(posedge clk);
    on <= 1'b1;
    n = 0;
    while (pin_oe_n[0] !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (pin_oe_n[0] === 1'b0 && n < 4000) begin
      if (pin_out[0] === 1'b0) n++;
      @(posedge clk);
    end
    chk(32'(n), 32'd3000);
    chk(pin_out[2], 1'b0);
    chk(irq_o, 1'b1);
    apb(1'b0, idp_pkg::OFF_IST, 32'h0000_0000);
    chk(rdata & 32'h0000_0020, 32'h0000_0020);
    apb(1'b1, idp_pkg::OFF_ICLR, 32'h0000_0020);
    repeat (3) @(posedge clk);
    chk(irq_o, 1'b0);
    apb(1'b1, idp_pkg::OFF_MODE, 32'h0000_2000);
    apb(1'b1, idp_pkg::OFF_OUTV, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk({pin_oe_n[6], pin_out[6]}, 2'h0);
    apb(1'b1, idp_pkg::OFF_INV, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk(pin_out[6], 1'b1);
    apb(1'b1, idp_pkg::OFF_INV, 32'h0000_0000);
    apb(1'b1, idp_pkg::OFF_OUTV, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(pin_out[6], 1'b1);
    apb(1'b1, idp_pkg::OFF_MODE, 32'h0000_1000);
    for (int v = 0; v < 2; v++) begin
      ext.hold(6, v[0]);
      repeat (5) @(posedge clk);
      apb(1'b0, idp_pkg::OFF_PINST, 32'h0000_0000);
      chk(rdata[6], v[0]);
    end
    ext.release_pin(6);
    apb(1'b1, idp_pkg::OFF_PER, 32'h0000_000A);
    apb(1'b1, idp_pkg::OFF_MODE, 32'h0000_3000);
    foreach (duties[i]) begin
      apb(1'b1, idp_pkg::OFF_DUTY, 32'(duties[i]));
      repeat (30) @(posedge clk);
      n = 0;
      repeat (10) begin
        @(posedge clk);
        if (pin_out[6] === 1'b0) n++;
      end
      chk(32'(n), 32'(duties[i]));
    end
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    chk(rdata, 32'h0000_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
